// File: rtl/cfio_port_block.sv
// cfio_port_block: run-time configurable i/o ports a..g with their
// configuration and data registers, reached by mcu bus cycles.
// assumes bus strobes and pins are asynchronous and are synchronised
// here; latched address and logic-array terms come from this clock.
`timescale 1ns/10ps
`default_nettype none
module cfio_port_block
    import cfio_pkg::*;
#(
    parameter logic        DATA_PORT_MODE   = 1'b0,
    parameter logic        RESET_PATTERN_EN = 1'b0,
    parameter logic [15:0] RESET_PATTERN    = 16'h0000,
    parameter logic [7:0]  LOGIC_OUT_SEL_A  = 8'h00,
    parameter logic [7:0]  LOGIC_OUT_SEL_B  = 8'h00,
    parameter logic        ADDR_IN_LATCH    = 1'b0,
    parameter logic        CSI_EN           = 1'b0
) (
    input  wire logic                           ref_clk_in,      // 50 mhz clock
    input  wire logic                           rstn_in,         // sync reset, low
    input  wire logic [NUM_PORTS-1:0][PORT_W-1:0] port_pins_in,  // pin levels
    output logic      [NUM_PORTS-1:0][PORT_W-1:0] port_pins_out, // pin drive level
    output logic      [NUM_PORTS-1:0][PORT_W-1:0] port_pins_oe_out, // pin enables
    output logic      [NUM_PORTS-1:0][PORT_W-1:0] slew_fast_out, // fast slew select
    input  wire logic                           mcu_reset_n_in,  // mcu reset, low
    input  wire logic                           bus_rd_n_in,     // read strobe, low
    input  wire logic                           bus_wr_n_in,     // write strobe, low
    input  wire logic                           window_sel_in,   // window decoded
    input  wire logic [ADDR_W-1:0]              bus_addr_in,     // window offset
    input  wire logic [1:0]                     bus_byte_en_in,  // lane enables
    input  wire logic [DATA_W-1:0]              mcu_data_in,     // data bus in
    output logic      [DATA_W-1:0]              mcu_data_out,    // data bus out
    output logic                                mcu_data_oe_out, // data bus enable
    input  wire logic [15:0]                    latched_addr_in, // latched address
    input  wire logic [1:0][PORT_W-1:0]         logic_out_in,    // array outputs a,b
    input  wire logic [NUM_PORTS-1:0][PORT_W-1:0] logic_oe_in,   // enable terms
    output logic      [15:0]                    logic_addr_out   // address to array
);

    // ==========================================================
    // synchronisers for pins and bus signals
    logic [NUM_PORTS-1:0][PORT_W-1:0] pins_s;
    logic [3:0]                       ctrl_s;
    logic [25:0]                      pay_s;

    cfio_sync2 #(
        .WIDTH   (NUM_PORTS*PORT_W),
        .RST_VAL ('0)
    ) u_pin_sync (
        .clk_in   (ref_clk_in),
        .rstn_in  (rstn_in),
        .async_in (port_pins_in),
        .sync_out (pins_s)
    );

    cfio_sync2 #(
        .WIDTH   (4),
        .RST_VAL (CTRL_SYNC_RST)
    ) u_ctrl_sync (
        .clk_in   (ref_clk_in),
        .rstn_in  (rstn_in),
        .async_in ({mcu_reset_n_in, bus_rd_n_in, bus_wr_n_in, window_sel_in}),
        .sync_out (ctrl_s)
    );

    // address, lanes and data settle before the strobe, so they are
    // stable by the time the synchronised strobe is seen
    cfio_sync2 #(
        .WIDTH   (26),
        .RST_VAL ('0)
    ) u_pay_sync (
        .clk_in   (ref_clk_in),
        .rstn_in  (rstn_in),
        .async_in ({bus_addr_in, bus_byte_en_in, mcu_data_in}),
        .sync_out (pay_s)
    );

    logic              mcu_rst_n_s;
    logic              rd_n_s;
    logic              wr_n_s;
    logic              win_s;
    logic [ADDR_W-1:0] addr_s;
    logic [1:0]        be_s;
    logic [15:0]       wdata_s;
    logic              cs_n_s;

    // split the synchronised bundles into named levels
    assign mcu_rst_n_s = ctrl_s[3];
    assign rd_n_s      = ctrl_s[2];
    assign wr_n_s      = ctrl_s[1];
    assign win_s       = ctrl_s[0];
    assign addr_s      = pay_s[25:18];
    assign be_s        = pay_s[17:16];
    assign cs_n_s      = pins_s[PORT_D][PIN_CSN];
    // in data port mode ports f and g are the data bus itself
    assign wdata_s     = DATA_PORT_MODE ? {pins_s[PORT_G], pins_s[PORT_F]}
                                        : pay_s[15:0];

    // ==========================================================
    // configuration and data registers
    logic [NUM_PORTS-1:0][7:0] mode_reg;
    logic [NUM_PORTS-1:0][7:0] mode_next;
    logic [NUM_PORTS-1:0][7:0] dir_reg;
    logic [NUM_PORTS-1:0][7:0] dir_next;
    logic [NUM_PORTS-1:0][7:0] drv_reg;
    logic [NUM_PORTS-1:0][7:0] drv_next;
    logic [NUM_PORTS-1:0][7:0] dout_reg;
    logic [NUM_PORTS-1:0][7:0] dout_next;

    // ==========================================================
    // bus cycle tracking
    cfio_bus_state_t bus_state_reg;
    cfio_bus_state_t bus_state_next;
    logic            access_ok;
    logic            wr_fire;

    // chip select high shuts the window; the port logic runs on
    always_comb begin
        access_ok      = win_s & (~CSI_EN | ~cs_n_s);
        wr_fire        = 1'b0;
        bus_state_next = bus_state_reg;
        case (bus_state_reg)
            BUS_IDLE: begin
                if (!wr_n_s && access_ok) begin
                    bus_state_next = BUS_WRITE;
                    wr_fire        = 1'b1;
                end else if (!rd_n_s && access_ok) begin
                    bus_state_next = BUS_READ;
                end
            end
            BUS_WRITE: begin
                // one write per strobe, however long it is held
                if (wr_n_s) begin
                    bus_state_next = BUS_IDLE;
                end
            end
            BUS_READ: begin
                if (rd_n_s) begin
                    bus_state_next = BUS_IDLE;
                end
            end
            default: begin
                bus_state_next = BUS_IDLE;
            end
        endcase
        if (!rstn_in) begin
            bus_state_next = BUS_IDLE;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        bus_state_reg <= bus_state_next;
    end

    // ==========================================================
    // byte read decode
    function automatic logic [7:0] read_byte(input logic [ADDR_W-1:0] a);
        logic [3:0] grp;
        logic [3:0] prt;
        logic [7:0] rb;
        grp = a[7:4];
        prt = a[3:0];
        rb  = BYTE_ZERO;
        if (prt < PORT_LIMIT) begin
            case (grp)
                GRP_DIN:  rb = pins_s[prt[2:0]] & PIN_IMPL[prt[2:0]];
                GRP_DOUT: rb = dout_reg[prt[2:0]];
                GRP_DIR:  rb = dir_reg[prt[2:0]];
                GRP_DRV:  rb = drv_reg[prt[2:0]];
                GRP_MODE: rb = mode_reg[prt[2:0]];
                default:  rb = BYTE_ZERO;
            endcase
        end
        return rb;
    endfunction

    // ==========================================================
    // register writes, one byte lane at a time
    always_comb begin
        logic [ADDR_W-1:0] la;
        logic [2:0]        lp;
        logic [7:0]        lb;
        la        = '0;
        lp        = '0;
        lb        = BYTE_ZERO;
        mode_next = mode_reg;
        dir_next  = dir_reg;
        drv_next  = drv_reg;
        dout_next = dout_reg;
        if (wr_fire) begin
            for (int ln = 0; ln < 2; ln++) begin
                la = {addr_s[7:1], ln[0]};
                lp = la[2:0];
                lb = wdata_s[ln*8 +: 8];
                if (be_s[ln] && la[3:0] < PORT_LIMIT) begin
                    case (la[7:4])
                        GRP_DOUT: dout_next[lp] = lb & PIN_IMPL[lp];
                        GRP_DIR:  dir_next[lp]  = lb & PIN_IMPL[lp];
                        GRP_DRV:  drv_next[lp]  = lb & PIN_IMPL[lp];
                        GRP_MODE: mode_next[lp] = lb & MODE_IMPL[lp];
                        default:  lb = lb;
                    endcase
                end
            end
        end
        if (!rstn_in) begin
            mode_next = '{default: REG_RESET};
            dir_next  = '{default: REG_RESET};
            drv_next  = '{default: REG_RESET};
            dout_next = '{default: REG_RESET};
        end
    end

    always_ff @(posedge ref_clk_in) begin
        mode_reg <= mode_next;
        dir_reg  <= dir_next;
        drv_reg  <= drv_next;
        dout_reg <= dout_next;
    end

    // ==========================================================
    // data bus drive: read answer or reset pattern
    logic        bus_drv_reg;
    logic        bus_drv_next;
    logic [15:0] bus_val_reg;
    logic [15:0] bus_val_next;
    logic        pattern_act;

    // the pattern yields to any strobe so it never fights a cycle
    always_comb begin
        pattern_act  = RESET_PATTERN_EN & ~mcu_rst_n_s
                     & rd_n_s & wr_n_s;
        bus_drv_next = 1'b0;
        bus_val_next = bus_val_reg;
        if (bus_state_next == BUS_READ) begin
            bus_drv_next = 1'b1;
            bus_val_next = {read_byte({addr_s[7:1], 1'b1}),
                            read_byte({addr_s[7:1], 1'b0})};
        end else if (pattern_act) begin
            bus_drv_next = 1'b1;
            bus_val_next = RESET_PATTERN;
        end
        if (!rstn_in) begin
            bus_drv_next = 1'b0;
            bus_val_next = '0;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        bus_drv_reg <= bus_drv_next;
        bus_val_reg <= bus_val_next;
    end

    // separate data pins are only used when f and g are not the bus
    assign mcu_data_out    = bus_val_reg;
    assign mcu_data_oe_out = bus_drv_reg & ~DATA_PORT_MODE;

    // ==========================================================
    // per-pin value, enable and driver type
    logic [NUM_PORTS-1:0][7:0] pin_val;
    logic [NUM_PORTS-1:0][7:0] pin_en;
    logic [NUM_PORTS-1:0][7:0] pin_od;
    logic [NUM_PORTS-1:0][7:0] slew_next;

    // every bit works on its own pin index; no cross-pin terms
    always_comb begin
        for (int p = 0; p < NUM_PORTS; p++) begin
            pin_en[p]  = dir_reg[p] | logic_oe_in[p];
            pin_val[p] = dout_reg[p];
            for (int b = 0; b < PORT_W; b++) begin
                if (mode_reg[p][b]) begin
                    pin_val[p][b] = ADDR_HI_PORTS[p] ? latched_addr_in[8+b]
                                                     : latched_addr_in[b];
                end
            end
            pin_od[p]    = SLEW_PORTS[p] ? BYTE_ZERO : drv_reg[p];
            slew_next[p] = SLEW_PORTS[p] ? drv_reg[p] : BYTE_ZERO;
            pin_en[p]    = pin_en[p] & PIN_IMPL[p];
        end
        // logic array outputs replace mcu data on the chosen a/b pins
        pin_val[PORT_A] = (pin_val[PORT_A] & ~LOGIC_OUT_SEL_A)
                        | (logic_out_in[0] & LOGIC_OUT_SEL_A);
        pin_val[PORT_B] = (pin_val[PORT_B] & ~LOGIC_OUT_SEL_B)
                        | (logic_out_in[1] & LOGIC_OUT_SEL_B);
        if (DATA_PORT_MODE) begin
            // f and g follow the bus; the pattern ends with mcu reset
            pin_val[PORT_F] = bus_val_reg[7:0];
            pin_val[PORT_G] = bus_val_reg[15:8];
            pin_en[PORT_F]  = {PORT_W{bus_drv_reg}};
            pin_en[PORT_G]  = {PORT_W{bus_drv_reg}};
            pin_od[PORT_F]  = BYTE_ZERO;
            pin_od[PORT_G]  = BYTE_ZERO;
        end
        if (!rstn_in) begin
            slew_next = '0;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        slew_fast_out <= slew_next;
    end

    // ==========================================================
    // registered pin stages, one per port
    for (genvar gp = 0; gp < NUM_PORTS; gp++) begin : g_port
        cfio_pin_drive #(
            .W (PORT_W)
        ) u_drive (
            .clk_in     (ref_clk_in),
            .rstn_in    (rstn_in),
            .val_in     (pin_val[gp]),
            .en_in      (pin_en[gp]),
            .od_in      (pin_od[gp]),
            .pin_out    (port_pins_out[gp]),
            .pin_oe_out (port_pins_oe_out[gp])
        );
    end

    // ==========================================================
    // address inputs from ports a (low byte) and b (high byte) to the logic array
    logic [15:0] laddr_next;

    // with latching on, the value follows the pins only while the
    // strobe is high and then holds, like a transparent latch
    always_comb begin
        laddr_next = logic_addr_out;
        if (!ADDR_IN_LATCH || pins_s[PORT_D][PIN_ALE]) begin
            laddr_next = {pins_s[PORT_B], pins_s[PORT_A]};
        end
        if (!rstn_in) begin
            laddr_next = '0;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        logic_addr_out <= laddr_next;
    end

endmodule
`default_nettype wire

// File: shared/cfio_pkg.sv
// cfio_pkg: constants shared by the configurable I/O port block.
// assumes ports A..G are indexed 0..6 and each port is eight pins wide.
package cfio_pkg;

    // ==========================================================
    // port geometry
    localparam int NUM_PORTS = 7;
    localparam int PORT_W    = 8;
    localparam int ADDR_W    = 8;
    localparam int DATA_W    = 16;
    localparam int PORT_A    = 0;
    localparam int PORT_B    = 1;
    localparam int PORT_D    = 3;
    localparam int PORT_F    = 5;
    localparam int PORT_G    = 6;

    // port d pin roles when used as dedicated inputs
    localparam int PIN_ALE   = 0;
    localparam int PIN_CSN   = 2;

    // ==========================================================
    // register window: byte offset = {group, port index}
    localparam logic [3:0] GRP_DIN  = 4'h0;
    localparam logic [3:0] GRP_DOUT = 4'h1;
    localparam logic [3:0] GRP_DIR  = 4'h2;
    localparam logic [3:0] GRP_DRV  = 4'h3;
    localparam logic [3:0] GRP_MODE = 4'h4;
    localparam logic [3:0] PORT_LIMIT = 4'h7;

    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] BYTE_ZERO = 8'h00;

    // ==========================================================
    // implemented bits per port, index 6 (G) first
    localparam logic [NUM_PORTS-1:0][7:0] PIN_IMPL =
        {8'hff, 8'hff, 8'hff, 8'h0f, 8'hff, 8'hff, 8'hff};
    localparam logic [NUM_PORTS-1:0][7:0] MODE_IMPL =
        {8'hff, 8'hff, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00};

    // drive select meaning: slew on c and f, open drain elsewhere
    localparam logic [NUM_PORTS-1:0] SLEW_PORTS    = 7'h24;
    // port g carries the high address byte in address-out mode
    localparam logic [NUM_PORTS-1:0] ADDR_HI_PORTS = 7'h40;

    // sync reset image of {mcu_reset_n, rd_n, wr_n, window_sel}
    localparam logic [3:0] CTRL_SYNC_RST = 4'he;

    // ==========================================================
    // bus cycle tracker
    typedef enum logic [2:0] {
        BUS_IDLE  = 3'b001,
        BUS_READ  = 3'b010,
        BUS_WRITE = 3'b100
    } cfio_bus_state_t;

endpackage

// File: rtl/cfio_sync2.sv
// cfio_sync2: two-flop synchroniser for a bundle of levels.
// assumes each bit is an independent level; no word coherence.
`timescale 1ns/10ps
`default_nettype none
module cfio_sync2 #(
    parameter int               WIDTH   = 8,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input  wire logic             clk_in,   // block clock
    input  wire logic             rstn_in,  // sync reset, low
    input  wire logic [WIDTH-1:0] async_in, // foreign levels
    output logic      [WIDTH-1:0] sync_out  // safe levels
);
    logic [WIDTH-1:0] meta_reg;
    logic [WIDTH-1:0] meta_next;
    logic [WIDTH-1:0] sync_next;

    // ==========================================================
    // first stage feeds only the second stage
    always_comb begin
        meta_next = rstn_in ? async_in : RST_VAL;
        sync_next = rstn_in ? meta_reg : RST_VAL;
    end

    always_ff @(posedge clk_in) begin
        meta_reg <= meta_next;
        sync_out <= sync_next;
    end
endmodule
`default_nettype wire

// File: rtl/cfio_pin_drive.sv
// cfio_pin_drive: registered output stage for one port.
// assumes value, enable and open-drain select arrive on the same clock.
`timescale 1ns/10ps
`default_nettype none
module cfio_pin_drive #(
    parameter int W = 8
) (
    input  wire logic         clk_in,   // block clock
    input  wire logic         rstn_in,  // sync reset, low
    input  wire logic [W-1:0] val_in,   // level to present
    input  wire logic [W-1:0] en_in,    // pin drive wanted
    input  wire logic [W-1:0] od_in,    // open drain select
    output logic      [W-1:0] pin_out,  // pin output level
    output logic      [W-1:0] pin_oe_out // pin output enable
);
    logic [W-1:0] pin_next;
    logic [W-1:0] oe_next;

    // ==========================================================
    // open drain only pulls low; a high is left to the pull-up
    always_comb begin
        pin_next = val_in & ~od_in;
        oe_next  = en_in & (~od_in | ~val_in);
        if (!rstn_in) begin
            pin_next = '0;
            oe_next  = '0;
        end
    end

    always_ff @(posedge clk_in) begin
        pin_out    <= pin_next;
        pin_oe_out <= oe_next;
    end
endmodule
`default_nettype wire

// File: test/cfio_port_block_props.sv
// cfio_port_block_props: bus timing and gating checks at the block pins.
// assumes it is bound to cfio_port_block and sees only its ports.
`timescale 1ns/10ps
`default_nettype none
module cfio_port_block_props
    import cfio_pkg::*;
(
    input wire logic                             ref_clk_in,       // block clock
    input wire logic                             rstn_in,          // sync reset, low
    input wire logic [NUM_PORTS-1:0][PORT_W-1:0] port_pins_in,     // pin levels
    input wire logic [NUM_PORTS-1:0][PORT_W-1:0] port_pins_oe_out, // pin enables
    input wire logic [NUM_PORTS-1:0][PORT_W-1:0] slew_fast_out,    // slew select
    input wire logic                             bus_rd_n_in,      // read strobe
    input wire logic                             bus_wr_n_in,      // write strobe
    input wire logic                             mcu_reset_n_in,   // mcu reset
    input wire logic                             window_sel_in,    // window select
    input wire logic                             mcu_data_oe_out,  // bus enable
    input wire logic [15:0]                      logic_addr_out    // array address
);
    // ====================
    // properties; strobes pass two sync flops, so causes sit 2 edges back
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rstn_in);
    property p_rst_quiet; !$past(rstn_in) |-> !mcu_data_oe_out && port_pins_oe_out == '0
        && slew_fast_out == '0; endproperty
    a_rst_quiet: assert property (p_rst_quiet) else $error("outputs busy after reset");
    property p_rd_cause; $rose(mcu_data_oe_out) && mcu_reset_n_in |-> !$past(bus_rd_n_in, 2)
        && $past(window_sel_in, 2); endproperty
    a_rd_cause: assert property (p_rd_cause) else $error("bus driven without a read");
    property p_csn_gate; $rose(mcu_data_oe_out) |-> !$past(port_pins_in[PORT_D][PIN_CSN], 2);
    endproperty
    a_csn_gate: assert property (p_csn_gate) else $error("bus driven while deselected");
    property p_no_oe_wr; !bus_wr_n_in [*4] |-> !mcu_data_oe_out; endproperty
    a_no_oe_wr: assert property (p_no_oe_wr) else $error("bus driven during write");
    property p_oe_rise; $fell(bus_rd_n_in) && window_sel_in
        && !port_pins_in[PORT_D][PIN_CSN] |-> ##[1:4] mcu_data_oe_out; endproperty
    a_oe_rise: assert property (p_oe_rise) else $error("read never answered");
    property p_oe_drop; $rose(bus_rd_n_in) |-> ##[1:4] !mcu_data_oe_out; endproperty
    a_oe_drop: assert property (p_oe_drop) else $error("bus held after read");
    property p_slew_ports; {slew_fast_out[PORT_G], slew_fast_out[4:3], slew_fast_out[1:0]}
        == '0; endproperty
    a_slew_ports: assert property (p_slew_ports) else $error("slew on drain port");
    property p_addr_in; $stable(port_pins_in[1:0]) [*5] |->
        logic_addr_out == {port_pins_in[PORT_B], port_pins_in[PORT_A]}; endproperty
    a_addr_in: assert property (p_addr_in) else $error("address inputs not passed");
    c_read: cover property ($rose(mcu_data_oe_out));
    c_write: cover property (!bus_wr_n_in && window_sel_in);
    c_refused: cover property (!bus_rd_n_in && port_pins_in[PORT_D][PIN_CSN]);
endmodule
bind cfio_port_block cfio_port_block_props cfio_port_block_props_inst (.ref_clk_in, .rstn_in,
    .port_pins_in, .port_pins_oe_out, .slew_fast_out, .bus_rd_n_in, .bus_wr_n_in,
    .window_sel_in, .mcu_data_oe_out, .mcu_reset_n_in, .logic_addr_out);
`default_nettype wire

// File: test/cfio_mcu_model.sv
// cfio_mcu_model: 16-bit controller issuing register cycles to the ports.
// assumes tasks are entered just after a clock edge.
`timescale 1ns/10ps
`default_nettype none
module cfio_mcu_model
    import cfio_pkg::*;
(
    input  wire logic              clk_in,      // block clock
    input  wire logic [DATA_W-1:0] data_in,     // bus from device
    input  wire logic              data_oe_in,  // device drives bus
    output logic                   reset_n_out, // controller reset, low
    output logic                   rd_n_out,    // read strobe, low
    output logic                   wr_n_out,    // write strobe, low
    output logic                   sel_out,     // window select
    output logic [ADDR_W-1:0]      addr_out,    // byte offset
    output logic [1:0]             be_out,      // lane enables
    output logic [DATA_W-1:0]      data_out     // bus to device
);
    // ====================
    // bus state
    logic [DATA_W-1:0] strap_val; // levels seen as reset lifts
    initial begin
        reset_n_out = 1'b0;
        rd_n_out = 1'b1;
        wr_n_out = 1'b1;
        sel_out = 1'b0;
        addr_out = 8'h00;
        be_out = 2'b00;
        data_out = 16'h0000;
    end
    // lift reset; the whole bus is taken as straps at that edge
    task automatic lift_reset();
        repeat (4) @(posedge clk_in);
        reset_n_out <= 1'b1;
        strap_val = data_in;
    endtask
    // one cycle; a read waits a bounded time, since a deselected device never answers
    task automatic xfer(input bit wr, input logic [7:0] a, input logic [7:0] d,
                        output logic [7:0] q, output bit ok);
        int n;
        addr_out <= a;
        be_out <= a[0] ? 2'b10 : 2'b01;
        data_out <= {d, d};
        sel_out <= 1'b1;
        repeat (2) @(posedge clk_in);
        rd_n_out <= wr;
        wr_n_out <= !wr;
        n = 0;
        while ((wr && n < 4) || (!wr && n < 8 && (n < 4 || !data_oe_in))) begin
            @(posedge clk_in);
            n++;
        end
        q = a[0] ? data_in[15:8] : data_in[7:0];
        ok = data_oe_in;
        rd_n_out <= 1'b1;
        wr_n_out <= 1'b1;
        sel_out <= 1'b0;
        addr_out <= ~a;
        data_out <= ~{d, d};
        repeat (5) @(posedge clk_in);
    endtask
endmodule
`default_nettype wire

// File: test/test_cfio_port_block.sv
// test_cfio_port_block: self-checking bench for the configurable port block.
// assumes package, design, checker and controller model are compiled first.
`timescale 1ns/10ps
`default_nettype none
module test_cfio_port_block
    import cfio_pkg::*;
;
    // ====================
    // stimulus, results and register model
    logic                             clk = 1'b0;  // 50 mhz clock
    logic                             rstn = 1'b0; // block reset
    logic [NUM_PORTS-1:0][PORT_W-1:0] pins = '0;   // pin levels
    logic [NUM_PORTS-1:0][PORT_W-1:0] loe = '0;    // logic enable terms
    logic [15:0]                      laddr = '0;  // latched address
    logic [1:0][PORT_W-1:0]           lout = '0;   // array outputs
    logic [NUM_PORTS-1:0][PORT_W-1:0] p_out, p_oe, slew;
    logic [DATA_W-1:0]                wdat, rdat;
    logic [ADDR_W-1:0]                addr;
    logic [1:0]                       be;
    logic                             rst_n, rd_n, wr_n, sel, rd_oe;
    logic [15:0]                      la_out;
    logic [7:0]                       mdl [5][7];  // expected registers
    int                               err_count = 0;
    int                               samples_checked = 0;
    // free-running clock
    always #10 clk = ~clk;
    cfio_port_block #(.CSI_EN(1'b1), .RESET_PATTERN_EN(1'b1), .RESET_PATTERN(16'h5a3c))
        cfio_port_block_inst (
        .ref_clk_in(clk), .rstn_in(rstn), .port_pins_in(pins), .port_pins_out(p_out),
        .port_pins_oe_out(p_oe), .slew_fast_out(slew), .mcu_reset_n_in(rst_n),
        .bus_rd_n_in(rd_n), .bus_wr_n_in(wr_n), .window_sel_in(sel), .bus_addr_in(addr),
        .bus_byte_en_in(be), .mcu_data_in(wdat), .mcu_data_out(rdat),
        .mcu_data_oe_out(rd_oe), .latched_addr_in(laddr), .logic_out_in(lout),
        .logic_oe_in(loe), .logic_addr_out(la_out));
    cfio_mcu_model cfio_mcu_model_inst (
        .clk_in(clk), .data_in(rdat), .data_oe_in(rd_oe), .reset_n_out(rst_n),
        .rd_n_out(rd_n), .wr_n_out(wr_n), .sel_out(sel), .addr_out(addr), .be_out(be),
        .data_out(wdat));
    // ====================
    // shared tasks
    task automatic check(input logic [7:0] seen, input logic [7:0] want, input string what);
        samples_checked++;
        if (seen !== want) begin
            err_count++;
            $display("[ERR] %0t %s: seen %h want %h", $time, what, seen, want);
        end
    endtask
    task automatic report_and_stop();
        $display("TB: %0d mismatches in %0d checks", err_count, samples_checked);
        if (err_count == 0 && samples_checked > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    // sweep config registers: random writes into the model, or reads against it
    task automatic walk(input bit wr);
        logic [7:0] q, d;
        bit ok;
        for (int g = 1; g < 5; g++) begin
            for (int p = 0; p < NUM_PORTS; p++) begin
                d = 8'($urandom);
                if (wr) mdl[g][p] = d & ((g == 4) ? MODE_IMPL[p] : PIN_IMPL[p]);
                cfio_mcu_model_inst.xfer(wr, 8'(16 * g + p), d, q, ok);
                if (!wr) check(q, mdl[g][p], "register readback");
            end
        end
    endtask
    // open drain keeps the level low and drives only the zeros
    task automatic pin_check();
        logic [7:0] en, val, od, oe, ab;
        for (int p = 0; p < NUM_PORTS; p++) begin
            ab = (p == PORT_G) ? laddr[15:8] : laddr[7:0];
            en = mdl[2][p] | loe[p];
            val = (mdl[4][p] & ab) | (~mdl[4][p] & mdl[1][p]);
            od = SLEW_PORTS[p] ? 8'h00 : mdl[3][p];
            oe = en & ~(od & val);
            check(p_oe[p], oe, "pin enable");
            check(p_out[p] & p_oe[p], val & oe, "pin level");
            check(slew[p], mdl[3][p] & ~od, "slew select");
        end
    endtask
    // ====================
    // test sequence
    initial begin
        logic [NUM_PORTS-1:0][PORT_W-1:0] rnd;
        logic [7:0] q;
        bit ok;
        void'($urandom(58));
        mdl = '{default: 8'h00};
        repeat (16) @(posedge clk);
        rstn <= 1'b1;
        cfio_mcu_model_inst.lift_reset();
        check(8'(cfio_mcu_model_inst.strap_val != 16'h5a3c), 8'h00, "strap");
        walk(1'b0);
        $display("test reset values done");
        repeat (2) begin
            walk(1'b1);
            walk(1'b0);
            laddr <= 16'($urandom);
            lout <= 16'($urandom);
            loe <= 56'({$urandom, $urandom} & {$urandom, $urandom}) & PIN_IMPL;
            repeat (3) @(posedge clk);
            pin_check();
        end
        $display("test pin drive done");
        rnd = 56'({$urandom, $urandom});
        rnd[PORT_D] = rnd[PORT_D] & 8'h0b;
        pins <= rnd;
        repeat (4) @(posedge clk);
        for (int p = 0; p < 8; p++) begin
            cfio_mcu_model_inst.xfer(1'b0, 8'(p), 8'h00, q, ok);
            check(q, (p < NUM_PORTS) ? rnd[p] : 8'h00, "pin input");
        end
        $display("test pin input done");
        rnd[PORT_D][PIN_CSN] = 1'b1;
        pins <= rnd;
        repeat (3) @(posedge clk);
        cfio_mcu_model_inst.xfer(1'b1, 8'h10, ~mdl[1][0], q, ok);
        cfio_mcu_model_inst.xfer(1'b0, 8'h10, 8'h00, q, ok);
        check(8'(ok), 8'h00, "deselected read");
        rnd[PORT_D][PIN_CSN] = 1'b0;
        pins <= rnd;
        repeat (3) @(posedge clk);
        walk(1'b0);
        $display("test chip select done");
        report_and_stop();
    end
    // watchdog, well past the few thousand cycles the sequence needs
    initial begin
        #200000;
        err_count++;
        $display("[ERR] %0t watchdog expired", $time);
        report_and_stop();
    end
endmodule
`default_nettype wire
